// *** fss_defs.vh ***
// Constants shared by the flash sequencer files
`ifndef FSS_DEFS_VH
`define FSS_DEFS_VH
// Command opcodes
`define FSS_OP_SET_WRITE_LATCH_CMD 8'h06
`define FSS_OP_WRDI 8'h04
`define FSS_OP_RDSR0 8'h05
`define FSS_OP_RDSR1 8'h35
`define FSS_OP_WRSR0 8'h01
`define FSS_OP_WRSR1 8'h31
`define FSS_OP_WRSR2 8'h11
`define FSS_OP_PP 8'h02
`define FSS_OP_QPP 8'h32
`define FSS_OP_SE 8'h20
`define FSS_OP_BE32 8'h52
`define FSS_OP_BE64 8'hd8
`define FSS_OP_CE0 8'h60
`define FSS_OP_CE1 8'hc7
`define FSS_OP_SUSPEND 8'h75
`define FSS_OP_RESUME 8'h7a
`define FSS_OP_SECERASE 8'h44
`define FSS_OP_SECPROG 8'h42
`define FSS_OP_SECREAD 8'h48
`define FSS_OP_RSTEN 8'h66
`define FSS_OP_RST 8'h99
// Status byte 0 and byte 1 bit positions
`define FSS_SR0_WIP 0
`define FSS_SR0_WEL 1
`define FSS_SR1_PROGRAM_SUSPENDED_FLAG 2
`define FSS_SR1_LB1 3
`define FSS_SR1_ERASE_SUSPENDED_FLAG 7
// Security region address fields
`define FSS_SEC_TOP 8'h00
`define FSS_SEC_FIRST 4'h1
`define FSS_SEC_LAST 4'h3
`define FSS_SEC_GAP 2'h0
`define FSS_SEC_BYTES 1024
// Timing: clock period and resume latency in ns, derived cycle count
`define FSS_CLK_NS 10
`define FSS_T_RESUME_NS 200
`define FSS_RESUME_CYC ((`FSS_T_RESUME_NS + `FSS_CLK_NS - 1) / `FSS_CLK_NS)
// Default operation times in cycles
`define FSS_PROG_CYC 4000
`define FSS_ERASE_CYC 4000
`define FSS_CHIP_CYC 4000
`define FSS_SECERASE_CYC 2048
`define FSS_SECPROG_CYC 1000
`define FSS_WRSR_CYC 1000
`define FSS_SUS_CYC 2000
`define FSS_RST_CYC 3000
`endif

// *** fss_fifo.v ***
// Small synchronous FIFO for program data bytes
`timescale 1ns/1ps
`default_nettype none
module fss_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire reset_n,
  input wire clear,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage words
  reg [AW-1:0] wrPtr_r; // Write slot
  reg [AW-1:0] rdPtr_r; // Read slot
  reg [AW:0] count_r; // Words held
  wire push;
  wire pop;
  assign inReady = (count_r != DEPTH[AW:0]);
  assign outValid = (count_r != {(AW+1){1'b0}});
  assign outData = mem[rdPtr_r];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  // Data write
  always @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end
  // Pointers and fill count
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else if (clear) begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr_r <= (wrPtr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= (rdPtr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_r + 1'b1;
      end
      count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule
`default_nettype wire

// *** fss_flash_seq.v ***
// Serial flash command sequencer: suspend/resume, security regions, soft reset
`timescale 1ns/1ps
`default_nettype none
`include "fss_defs.vh"
module fss_flash_seq #(
  parameter FIFO_DEPTH = 8,
  parameter [15:0] PROG_CYC = `FSS_PROG_CYC,
  parameter [15:0] ERASE_CYC = `FSS_ERASE_CYC,
  parameter [15:0] CHIP_CYC = `FSS_CHIP_CYC,
  parameter [15:0] SECERASE_CYC = `FSS_SECERASE_CYC,
  parameter [15:0] SECPROG_CYC = `FSS_SECPROG_CYC,
  parameter [15:0] WRSR_CYC = `FSS_WRSR_CYC,
  parameter [15:0] SUS_CYC = `FSS_SUS_CYC,
  parameter [15:0] RST_CYC = `FSS_RST_CYC
) (
  input wire clk,
  input wire reset_n,
  input wire spiCsN,
  input wire spiSclk,
  input wire spiMosi,
  output reg spiMisoOut,
  output reg spiMisoOeN,
  input wire [2:0] secregLock,
  output reg inProgressFlag,
  output reg writeEnableLatch,
  output reg eraseSuspendedFlag,
  output reg programSuspendedFlag,
  output reg resetBusy
);
  // Sequencer states
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_BUSY = 3'd1;
  localparam [2:0] ST_SUSPENDING = 3'd2;
  localparam [2:0] ST_SUSPENDED = 3'd3;
  localparam [2:0] ST_RESUMING = 3'd4;
  localparam [2:0] ST_RESET = 3'd5;
  // Operation kinds
  localparam [2:0] OP_PROG = 3'd0;
  localparam [2:0] OP_ERASE = 3'd1;
  localparam [2:0] OP_CHIP = 3'd2;
  localparam [2:0] OP_SECERASE = 3'd3;
  localparam [2:0] OP_SECPROG = 3'd4;
  localparam [2:0] OP_WRSR = 3'd5;
  localparam [15:0] RESUME_CYC = `FSS_RESUME_CYC;
  localparam [15:0] SEC_BYTES = `FSS_SEC_BYTES;

  // Security region storage, all three regions back to back
  reg [7:0] secMem [0:3*`FSS_SEC_BYTES-1];
  integer i;
  // Regions start erased
  initial begin
    for (i = 0; i < 3*`FSS_SEC_BYTES; i = i + 1) begin
      secMem[i] = 8'hff;
    end
  end

  // Flat memory index from region number (1..3) and byte offset
  function [11:0] secIndex;
    input [1:0] region;
    input [9:0] offset;
    begin
      secIndex = {region - 2'd1, offset};
    end
  endfunction

  // Busy time of each operation kind
  function [15:0] opLimit;
    input [2:0] kind;
    begin
      case (kind)
        OP_PROG: opLimit = PROG_CYC;
        OP_ERASE: opLimit = ERASE_CYC;
        OP_CHIP: opLimit = CHIP_CYC;
        OP_SECERASE: opLimit = SECERASE_CYC;
        OP_SECPROG: opLimit = SECPROG_CYC;
        default: opLimit = WRSR_CYC;
      endcase
    end
  endfunction

  // Pin synchronisers and edge history
  reg csS1_r, csS2_r, csPrev_r;
  reg sclkS1_r, sclkS2_r, sclkPrev_r;
  reg siS1_r, siS2_r;
  wire csRise = csS2_r && !csPrev_r;
  wire sclkRise = sclkS2_r && !sclkPrev_r;
  wire sclkFall = !sclkS2_r && sclkPrev_r;
  // Two flops per pin before any logic
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      csS1_r <= 1'b1;
      csS2_r <= 1'b1;
      csPrev_r <= 1'b1;
      sclkS1_r <= 1'b0;
      sclkS2_r <= 1'b0;
      sclkPrev_r <= 1'b0;
      siS1_r <= 1'b0;
      siS2_r <= 1'b0;
    end else begin
      csS1_r <= spiCsN;
      csS2_r <= csS1_r;
      csPrev_r <= csS2_r;
      sclkS1_r <= spiSclk;
      sclkS2_r <= sclkS1_r;
      sclkPrev_r <= sclkS2_r;
      siS1_r <= spiMosi;
      siS2_r <= siS1_r;
    end
  end

  // Frame state
  reg [7:0] shift_r; // Incoming bits
  reg [2:0] bitCnt_r; // Bit within byte
  reg [7:0] byteCnt_r; // Bytes in frame, saturating
  reg [7:0] opcode_r; // First byte of the frame
  reg [23:0] addr_r; // Address bytes
  reg [9:0] rdOffset_r; // Security read offset
  reg [7:0] txByte_r; // Byte being shifted out
  reg txOn_r; // Output phase active
  reg execPulse_r; // Frame ended on a byte boundary
  reg cutPulse_r; // Frame ended in mid-byte
  reg [7:0] execBytes_r; // Byte count of that frame
  reg pushValid_r; // Program data byte to FIFO
  reg [7:0] pushData_r;
  wire [7:0] newByte = {shift_r[6:0], siS2_r};
  wire [7:0] curOp = (byteCnt_r == 8'h00) ? newByte : opcode_r; // Opcode, live during its own byte
  wire [3:0] secRegion = addr_r[15:12];
  // Engine state, declared here for the frame logic
  reg [2:0] state_r;
  reg [2:0] opKind_r;
  wire fifoInReady;
  wire fifoOutValid;
  wire [7:0] fifoOutData;
  reg fifoPop;
  reg fifoClear_r;
  // Status bytes as seen by status reads
  wire [7:0] status0 = {6'h00, writeEnableLatch, inProgressFlag};
  wire [7:0] status1 = {eraseSuspendedFlag, 1'b0, secregLock, programSuspendedFlag, 2'h0};
  // Region address check
  // top byte zero, region 1..3, gap bits zero
  wire secAddrOk = (addr_r[23:16] == `FSS_SEC_TOP) && (secRegion >= `FSS_SEC_FIRST) &&
                   (secRegion <= `FSS_SEC_LAST) && (addr_r[11:10] == `FSS_SEC_GAP);
  // lock bit of the addressed region
  wire secLocked = |(secregLock & (3'b001 << (addr_r[13:12] - 2'd1)));

  // Serial frame receive and transmit
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_r <= 8'h00;
      bitCnt_r <= 3'h0;
      byteCnt_r <= 8'h00;
      opcode_r <= 8'h00;
      addr_r <= 24'h000000;
      rdOffset_r <= 10'h000;
      txByte_r <= 8'hff;
      txOn_r <= 1'b0;
      execPulse_r <= 1'b0;
      cutPulse_r <= 1'b0;
      execBytes_r <= 8'h00;
      pushValid_r <= 1'b0;
      pushData_r <= 8'h00;
      spiMisoOut <= 1'b0;
      spiMisoOeN <= 1'b1;
    end else begin
      pushValid_r <= 1'b0;
      execPulse_r <= csRise && (bitCnt_r == 3'h0);
      // A cut frame leaves its data bytes unused
      cutPulse_r <= csRise && (bitCnt_r != 3'h0);
      if (csRise) begin
        execBytes_r <= byteCnt_r;
      end
      if (csS2_r) begin
        // Deselected: frame counters clear, output released
        bitCnt_r <= 3'h0;
        byteCnt_r <= 8'h00;
        txOn_r <= 1'b0;
        spiMisoOeN <= 1'b1;
      end else begin
        if (sclkRise) begin
          shift_r <= newByte;
          bitCnt_r <= bitCnt_r + 3'h1;
          if (bitCnt_r == 3'h7) begin
            if (byteCnt_r != 8'hff) begin
              byteCnt_r <= byteCnt_r + 8'h01;
            end
            case (byteCnt_r)
              8'h00: opcode_r <= newByte;
              8'h01: addr_r[23:16] <= newByte;
              8'h02: addr_r[15:8] <= newByte;
              8'h03: begin
                addr_r[7:0] <= newByte;
                rdOffset_r <= {addr_r[9:8], newByte};
              end
              default: begin
              end
            endcase
            // Program data goes to the FIFO, extra bytes beyond its room are dropped
            if (opcode_r == `FSS_OP_SECPROG && byteCnt_r >= 8'h04 && state_r == ST_IDLE) begin
              pushValid_r <= fifoInReady;
              pushData_r <= newByte;
            end
            // Output byte loads at each byte end; status reads start right after the opcode
            if (state_r != ST_RESET) begin
              if (curOp == `FSS_OP_RDSR0) begin
                txByte_r <= status0;
                txOn_r <= 1'b1;
              end else if (curOp == `FSS_OP_RDSR1) begin
                txByte_r <= status1;
                txOn_r <= 1'b1;
              end else if (opcode_r == `FSS_OP_SECREAD && byteCnt_r >= 8'h04 && !inProgressFlag) begin
                // offset advances per byte, 3ff wraps to 000
                txByte_r <= secAddrOk ? secMem[secIndex(addr_r[13:12], rdOffset_r)] : 8'hff;
                rdOffset_r <= rdOffset_r + 10'h001;
                txOn_r <= 1'b1;
              end
            end
          end
        end
        // output bit changes on falling serial clock
        if (sclkFall && txOn_r) begin
          spiMisoOut <= txByte_r[3'h7 - bitCnt_r];
          spiMisoOeN <= 1'b0;
        end
      end
    end
  end

  // Program data FIFO between the frame and the write engine
  fss_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .clear(fifoClear_r),
    .inValid(pushValid_r),
    .inReady(fifoInReady),
    .inData(pushData_r),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoOutData)
  );

  // Engine state
  reg [15:0] opTimer_r; // Progress of the running operation
  reg [15:0] subTimer_r; // Suspend, resume and reset latencies
  reg [9:0] progOffset_r; // Next security byte to program
  reg [1:0] opRegion_r; // Region of the security operation
  reg resetArmed_r; // Reset enable frame seen
  wire isErase = (opcode_r == `FSS_OP_SE) || (opcode_r == `FSS_OP_BE32) || (opcode_r == `FSS_OP_BE64);
  wire isChip = (opcode_r == `FSS_OP_CE0) || (opcode_r == `FSS_OP_CE1);
  wire isWrsr = (opcode_r == `FSS_OP_WRSR0) || (opcode_r == `FSS_OP_WRSR1) || (opcode_r == `FSS_OP_WRSR2);
  wire isProg = (opcode_r == `FSS_OP_PP) || (opcode_r == `FSS_OP_QPP);
  wire suspended = eraseSuspendedFlag || programSuspendedFlag;
  wire opDone = (opTimer_r >= opLimit(opKind_r)) && !(opKind_r == OP_SECPROG && fifoOutValid);

  // Pop one program byte per cycle while a security program runs
  always @* begin
    fifoPop = (state_r == ST_BUSY) && (opKind_r == OP_SECPROG) && fifoOutValid;
  end

  // Security memory writes from the running operation
  always @(posedge clk) begin
    // each region written only through its own index range
    if (state_r == ST_BUSY && opKind_r == OP_SECERASE && opTimer_r < SEC_BYTES) begin
      secMem[secIndex(opRegion_r, opTimer_r[9:0])] <= 8'hff;
    end else if (fifoPop) begin
      secMem[secIndex(opRegion_r, progOffset_r)] <= secMem[secIndex(opRegion_r, progOffset_r)] & fifoOutData;
    end
  end

  // Command execution, suspend/resume and reset sequencing
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      opKind_r <= OP_PROG;
      opTimer_r <= 16'h0000;
      subTimer_r <= 16'h0000;
      progOffset_r <= 10'h000;
      opRegion_r <= 2'h1;
      resetArmed_r <= 1'b0;
      fifoClear_r <= 1'b0;
      inProgressFlag <= 1'b0;
      writeEnableLatch <= 1'b0;
      eraseSuspendedFlag <= 1'b0;
      programSuspendedFlag <= 1'b0;
      resetBusy <= 1'b0;
    end else begin
      fifoClear_r <= 1'b0;
      // Drop bytes of a cut program frame so no later frame reuses them
      if (cutPulse_r && state_r == ST_IDLE) begin
        fifoClear_r <= 1'b1;
      end
      if (fifoPop) begin
        progOffset_r <= progOffset_r + 10'h001;
      end
      if (execPulse_r && state_r != ST_RESET) begin
        // arm on enable frame, any other frame ending on a byte boundary disarms
        resetArmed_r <= (opcode_r == `FSS_OP_RSTEN) && (execBytes_r == 8'h01);
      end
      if (execPulse_r && state_r != ST_RESET && resetArmed_r &&
          opcode_r == `FSS_OP_RST && execBytes_r == 8'h01) begin
        // abort everything and return to defaults
        state_r <= ST_RESET;
        subTimer_r <= 16'h0000;
        inProgressFlag <= 1'b0;
        writeEnableLatch <= 1'b0;
        eraseSuspendedFlag <= 1'b0;
        programSuspendedFlag <= 1'b0;
        resetArmed_r <= 1'b0;
        fifoClear_r <= 1'b1;
        resetBusy <= 1'b1;
      end else begin
        case (state_r)
          ST_IDLE, ST_SUSPENDED: begin
            if (execPulse_r) begin
              if (opcode_r == `FSS_OP_SET_WRITE_LATCH_CMD && execBytes_r == 8'h01) begin
                writeEnableLatch <= 1'b1;
              end else if (opcode_r == `FSS_OP_WRDI && execBytes_r == 8'h01) begin
                writeEnableLatch <= 1'b0;
              end else if (state_r == ST_SUSPENDED) begin
                // resume only with a suspend flag up and busy low
                if (opcode_r == `FSS_OP_RESUME && execBytes_r == 8'h01) begin
                  eraseSuspendedFlag <= 1'b0;
                  programSuspendedFlag <= 1'b0;
                  subTimer_r <= 16'h0000;
                  state_r <= ST_RESUMING;
                end
                // forbidden commands during suspend leave all unchanged
                fifoClear_r <= 1'b1;
              end else if (writeEnableLatch) begin
                // Start of a self-timed operation clears the latch early
                if (isProg && execBytes_r >= 8'h05) begin
                  opKind_r <= OP_PROG;
                  state_r <= ST_BUSY;
                  opTimer_r <= 16'h0000;
                  inProgressFlag <= 1'b1;
                  writeEnableLatch <= 1'b0;
                end else if ((isErase && execBytes_r == 8'h04) || (isChip && execBytes_r == 8'h01)) begin
                  opKind_r <= isChip ? OP_CHIP : OP_ERASE;
                  state_r <= ST_BUSY;
                  opTimer_r <= 16'h0000;
                  inProgressFlag <= 1'b1;
                  writeEnableLatch <= 1'b0;
                end else if (isWrsr && execBytes_r >= 8'h02) begin
                  opKind_r <= OP_WRSR;
                  state_r <= ST_BUSY;
                  opTimer_r <= 16'h0000;
                  inProgressFlag <= 1'b1;
                  writeEnableLatch <= 1'b0;
                // opcode plus exactly three address bytes
                end else if (opcode_r == `FSS_OP_SECERASE && execBytes_r == 8'h04 && secAddrOk && !secLocked) begin
                  // self-timed erase with busy flag held
                  opKind_r <= OP_SECERASE;
                  opRegion_r <= addr_r[13:12];
                  state_r <= ST_BUSY;
                  opTimer_r <= 16'h0000;
                  inProgressFlag <= 1'b1;
                  writeEnableLatch <= 1'b0;
                end else if (opcode_r == `FSS_OP_SECPROG && execBytes_r >= 8'h05 && secAddrOk && !secLocked) begin
                  opKind_r <= OP_SECPROG;
                  opRegion_r <= addr_r[13:12];
                  progOffset_r <= addr_r[9:0];
                  state_r <= ST_BUSY;
                  opTimer_r <= 16'h0000;
                  inProgressFlag <= 1'b1;
                  writeEnableLatch <= 1'b0;
                end else begin
                  fifoClear_r <= 1'b1;
                end
              end else begin
                fifoClear_r <= 1'b1;
              end
            end
          end
          ST_BUSY: begin
            opTimer_r <= opTimer_r + 16'h0001;
            // suspend only for page program or sector/block erase
            if (execPulse_r && opcode_r == `FSS_OP_SUSPEND && execBytes_r == 8'h01 &&
                !suspended && inProgressFlag && (opKind_r == OP_PROG || opKind_r == OP_ERASE)) begin
              eraseSuspendedFlag <= (opKind_r == OP_ERASE);
              programSuspendedFlag <= (opKind_r == OP_PROG);
              opTimer_r <= opTimer_r;
              subTimer_r <= 16'h0000;
              state_r <= ST_SUSPENDING;
            end else if (opDone) begin
              inProgressFlag <= 1'b0;
              state_r <= ST_IDLE;
            end
          end
          ST_SUSPENDING: begin
            // busy flag falls after the suspend latency
            subTimer_r <= subTimer_r + 16'h0001;
            if (subTimer_r >= SUS_CYC - 16'h0001) begin
              inProgressFlag <= 1'b0;
              state_r <= ST_SUSPENDED;
            end
          end
          ST_RESUMING: begin
            // busy returns within the resume time, then finishes
            subTimer_r <= subTimer_r + 16'h0001;
            if (subTimer_r >= RESUME_CYC - 16'h0001) begin
              inProgressFlag <= 1'b1;
              state_r <= ST_BUSY;
            end
          end
          ST_RESET: begin
            // every frame refused until recovery ends
            subTimer_r <= subTimer_r + 16'h0001;
            if (subTimer_r >= RST_CYC - 16'h0001) begin
              resetBusy <= 1'b0;
              state_r <= ST_IDLE;
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** fss_host_model.sv ***
// Host side SPI controller model, mode 0, most significant bit first
`timescale 1ns/1ps
`default_nettype none
module fss_host_model (
  input wire clk,
  output logic spiCsN,
  output logic spiSclk,
  output logic spiMosi,
  input wire spiMisoOut,
  input wire spiMisoOeN
);
  logic [7:0] tx[$]; // Bytes to send
  logic [7:0] rx[$]; // Bytes read back
  // Idle bus at time zero
  initial begin
    spiCsN = 1'b1;
    spiSclk = 1'b0;
    spiMosi = 1'b0;
  end
  // One frame: send tx, then clock in nrx bytes
  // data set while clock low
  task automatic frame(input int nrx);
    logic [7:0] b;
    int n;
    n = tx.size() + nrx;
    rx = {};
    @(posedge clk) spiCsN <= 1'b0;
    for (int i = 0; i < n; i++) begin
      b = (i < tx.size()) ? tx[i] : 8'h00;
      for (int k = 7; k >= 0; k--) begin
        spiMosi <= b[k];
        repeat (8) @(posedge clk);
        spiSclk <= 1'b1;
        // Undriven output reads as unknown
        b[k] = spiMisoOeN ? 1'bx : spiMisoOut;
        repeat (8) @(posedge clk);
        spiSclk <= 1'b0;
      end
      if (i >= tx.size()) begin
        rx.push_back(b);
      end
    end
    repeat (8) @(posedge clk);
    spiCsN <= 1'b1;
    // Released data line keeps moving
    spiMosi <= ~spiMosi;
    tx = {};
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// *** fss_flash_seq_asserts.sv ***
// Port assertions for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module fss_flash_seq_asserts (
  input wire clk,
  input wire reset_n,
  input wire spiCsN,
  input wire spiSclk,
  input wire spiMosi,
  input wire spiMisoOut,
  input wire spiMisoOeN,
  input wire [2:0] secregLock,
  input wire inProgressFlag,
  input wire writeEnableLatch,
  input wire eraseSuspendedFlag,
  input wire programSuspendedFlag,
  input wire resetBusy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_oneSus; !(eraseSuspendedFlag && programSuspendedFlag); endproperty
  a_oneSus: assert property (p_oneSus) else $error("both suspend flags set");
  property p_eSusBusy; $rose(eraseSuspendedFlag) |-> inProgressFlag; endproperty
  a_eSusBusy: assert property (p_eSusBusy) else $error("erase suspend while idle");
  property p_pSusBusy; $rose(programSuspendedFlag) |-> inProgressFlag; endproperty
  a_pSusBusy: assert property (p_pSusBusy) else $error("program suspend while idle");
  property p_eResume; $fell(eraseSuspendedFlag) ##1 !resetBusy |-> ##[0:30] inProgressFlag; endproperty
  a_eResume: assert property (p_eResume) else $error("erase resume without busy");
  property p_pResume; $fell(programSuspendedFlag) ##1 !resetBusy |-> ##[0:30] inProgressFlag; endproperty
  a_pResume: assert property (p_pResume) else $error("program resume without busy");
  property p_rstClr; $rose(resetBusy) |-> !(inProgressFlag || writeEnableLatch || eraseSuspendedFlag
    || programSuspendedFlag); endproperty
  a_rstClr: assert property (p_rstClr) else $error("flags left after reset");
  property p_rstRefuse; resetBusy |-> !writeEnableLatch && !inProgressFlag; endproperty
  a_rstRefuse: assert property (p_rstRefuse) else $error("command acted in recovery");
  property p_oeIdle; spiCsN [*4] |=> spiMisoOeN; endproperty
  a_oeIdle: assert property (p_oeIdle) else $error("output driven while deselected");
  property p_frameStable; (!spiCsN) [*8] |-> $stable({writeEnableLatch, eraseSuspendedFlag,
    programSuspendedFlag}); endproperty
  a_frameStable: assert property (p_frameStable) else $error("flags moved inside frame");
endmodule
bind fss_flash_seq fss_flash_seq_asserts chk_u (.clk(clk), .reset_n(reset_n), .spiCsN(spiCsN), .spiSclk(spiSclk),
  .spiMosi(spiMosi), .spiMisoOut(spiMisoOut), .spiMisoOeN(spiMisoOeN), .secregLock(secregLock),
  .inProgressFlag(inProgressFlag), .writeEnableLatch(writeEnableLatch), .eraseSuspendedFlag(eraseSuspendedFlag),
  .programSuspendedFlag(programSuspendedFlag), .resetBusy(resetBusy));
`default_nettype wire

// *** tb_fss_flash_seq.sv ***
// Self-checking bench for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fss_defs.vh"
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin failCount++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb_fss_flash_seq;
  logic clk;
  logic reset_n;
  logic [2:0] secregLock;
  wire spiCsN, spiSclk, spiMosi, spiMisoOut, spiMisoOeN;
  wire inProgressFlag, writeEnableLatch, eraseSuspendedFlag, programSuspendedFlag, resetBusy;
  int failCount = 0;
  int compares = 0;
  // Short operation times keep the run brief
  fss_flash_seq #(.PROG_CYC(16'h0190), .ERASE_CYC(16'h0190), .SECERASE_CYC(16'h0400),
    .SECPROG_CYC(16'h0032), .SUS_CYC(16'h0032), .RST_CYC(16'h0190)) dut_u (.clk(clk), .reset_n(reset_n),
    .spiCsN(spiCsN), .spiSclk(spiSclk), .spiMosi(spiMosi), .spiMisoOut(spiMisoOut), .spiMisoOeN(spiMisoOeN),
    .secregLock(secregLock), .inProgressFlag(inProgressFlag), .writeEnableLatch(writeEnableLatch),
    .eraseSuspendedFlag(eraseSuspendedFlag), .programSuspendedFlag(programSuspendedFlag), .resetBusy(resetBusy));
  fss_host_model host_u (.clk(clk), .spiCsN(spiCsN), .spiSclk(spiSclk), .spiMosi(spiMosi),
    .spiMisoOut(spiMisoOut), .spiMisoOeN(spiMisoOeN));
  // Free running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic cmd(input logic [7:0] op);
    host_u.tx = {op};
    host_u.frame(0);
  endtask
  // Bounded wait for the busy flag to drop
  task automatic waitIdle;
    for (int i = 0; i < 3000 && inProgressFlag !== 1'b0; i++) @(posedge clk);
    `CHK("idle", 1'b0, inProgressFlag)
  endtask
  function automatic logic susOf(input logic [7:0] op);
    return (op == `FSS_OP_PP) ? programSuspendedFlag : eraseSuspendedFlag;
  endfunction
  // Suspend, refused commands, resume, on program or erase
  task automatic t_susp(input logic [7:0] op);
    cmd(`FSS_OP_SET_WRITE_LATCH_CMD);
    host_u.tx = {op, 8'h00, 8'h01, 8'h00};
    if (op == `FSS_OP_PP) begin
      host_u.tx.push_back(8'h5a);
    end
    host_u.frame(0);
    cmd(`FSS_OP_SUSPEND);
    `CHK("sus", 1'b1, susOf(op))
    repeat (60) @(posedge clk);
    `CHK("susIdle", 1'b0, inProgressFlag)
    cmd(`FSS_OP_SUSPEND);
    `CHK("susTwice", 1'b1, susOf(op))
    cmd(`FSS_OP_SET_WRITE_LATCH_CMD);
    host_u.tx = {`FSS_OP_SECERASE, 8'h00, 8'h20, 8'h00};
    host_u.frame(0);
    `CHK("noop", 1'b0, inProgressFlag)
    cmd(`FSS_OP_RESUME);
    `CHK("resClr", 1'b0, susOf(op))
    repeat (25) @(posedge clk);
    `CHK("resBusy", 1'b1, inProgressFlag)
    waitIdle;
    cmd(`FSS_OP_RESUME);
    `CHK("resIgn", 1'b0, inProgressFlag)
    $display("t_susp done");
  endtask
  // Program across the region end, read back with wrap
  task automatic t_sec;
    cmd(`FSS_OP_SET_WRITE_LATCH_CMD);
    host_u.tx = {`FSS_OP_SECPROG, 8'h00, 8'h23, 8'hff, 8'ha5, 8'h3c};
    host_u.frame(0);
    `CHK("pWip", 1'b1, inProgressFlag)
    `CHK("pWel", 1'b0, writeEnableLatch)
    waitIdle;
    host_u.tx = {`FSS_OP_SECREAD, 8'h00, 8'h23, 8'hff, 8'h00};
    host_u.frame(2);
    `CHK("rd0", 8'ha5, host_u.rx[0])
    `CHK("rd1", 8'h3c, host_u.rx[1])
    host_u.tx = {`FSS_OP_SECREAD, 8'h00, 8'h13, 8'hff, 8'h00};
    host_u.frame(1);
    `CHK("rg1", 8'hff, host_u.rx[0])
    $display("t_sec done");
  endtask
  // Locked region, malformed erase, then a valid erase
  task automatic t_lock;
    secregLock <= 3'b100;
    cmd(`FSS_OP_SET_WRITE_LATCH_CMD);
    host_u.tx = {`FSS_OP_SECPROG, 8'h00, 8'h30, 8'h00, 8'h00};
    host_u.frame(0);
    `CHK("lkProg", 1'b0, inProgressFlag)
    host_u.tx = {`FSS_OP_SECERASE, 8'h00, 8'h30, 8'h00};
    host_u.frame(0);
    `CHK("lkErase", 1'b0, inProgressFlag)
    host_u.tx = {`FSS_OP_SECERASE, 8'h00, 8'h20, 8'h00, 8'h00};
    host_u.frame(0);
    `CHK("longErase", 1'b0, inProgressFlag)
    cmd(`FSS_OP_SET_WRITE_LATCH_CMD);
    host_u.tx = {`FSS_OP_SECERASE, 8'h00, 8'h20, 8'h00};
    host_u.frame(0);
    `CHK("eWip", 1'b1, inProgressFlag)
    `CHK("eWel", 1'b0, writeEnableLatch)
    waitIdle;
    host_u.tx = {`FSS_OP_SECREAD, 8'h00, 8'h23, 8'hff, 8'h00};
    host_u.frame(1);
    `CHK("erased", 8'hff, host_u.rx[0])
    secregLock <= 3'b000;
    $display("t_lock done");
  endtask
  // Soft reset pair and recovery refusal
  task automatic t_rst;
    `CHK("preIdle", 1'b0, inProgressFlag)
    cmd(`FSS_OP_SET_WRITE_LATCH_CMD);
    cmd(`FSS_OP_RST);
    `CHK("loneRst", 1'b0, resetBusy)
    cmd(`FSS_OP_RSTEN);
    cmd(`FSS_OP_RST);
    `CHK("rstBusy", 1'b1, resetBusy)
    `CHK("rstWel", 1'b0, writeEnableLatch)
    cmd(`FSS_OP_SET_WRITE_LATCH_CMD);
    `CHK("refused", 1'b0, writeEnableLatch)
    repeat (300) @(posedge clk);
    `CHK("rstDone", 1'b0, resetBusy)
    cmd(`FSS_OP_SET_WRITE_LATCH_CMD);
    `CHK("welAgain", 1'b1, writeEnableLatch)
    $display("t_rst done");
  endtask
  task automatic closeOut;
    $display("compares=%0d failCount=%0d", compares, failCount);
    if (failCount == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #500000;
    failCount++;
    closeOut;
  end
  // Main sequence
  initial begin
    reset_n = 1'b0;
    secregLock = 3'b000;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_susp(`FSS_OP_PP);
    t_susp(`FSS_OP_SE);
    t_sec;
    t_lock;
    t_rst;
    closeOut;
  end
endmodule
`default_nettype wire
